// *** acfg_pkg.sv ***
// package: register map, field layout and encodings for channel config
package acfg_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0]  ACFG_OFF_CONFIG  = 4'h0;
	localparam logic [3:0]  ACFG_OFF_STATUS  = 4'h4;
	localparam logic [3:0]  ACFG_OFF_CORNER  = 4'h8;
	localparam logic [15:0] ACFG_CONFIG_RST  = 16'h0000;
	localparam logic [3:0]  ACFG_CORNER_RST  = 4'h0;
	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int          ACFG_PHASE_LSB   = 6;
	localparam int          ACFG_PHASE_MSB   = 15;
	localparam int          ACFG_HPOFF_BIT   = 2;
	localparam int          ACFG_SEL_LSB     = 0;
	localparam int          ACFG_SEL_MSB     = 1;
	localparam logic [15:0] ACFG_WMASK       = 16'hffc7;
	localparam logic [1:0]  ACFG_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  ACFG_RESP_SLVERR = 2'b10;
	// ------------------------------------------------------------
	// input select encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ACFG_SEL_EXTERNAL = 2'b00,
		ACFG_SEL_SHORTED  = 2'b01,
		ACFG_SEL_TEST_POS = 2'b10,
		ACFG_SEL_TEST_NEG = 2'b11
	} acfg_sel_t;
endpackage : acfg_pkg

// *** acfg_route.sv ***
// input routing and filter steering from the channel config fields
`timescale 1ns/10ps
module acfg_route
	import acfg_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [1:0] channel_input_select,
	input  wire logic       channel_highpass_off,
	input  wire logic       global_highpass_on,
	output logic            route_external,
	output logic            route_shorted,
	output logic            route_test_pos,
	output logic            route_test_neg,
	output logic            highpass_enable
);
	logic [3:0] route_q;
	logic [3:0] route_d;
	logic       hp_q;
	logic       hp_d;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	always_comb begin
		route_d = 4'h0;
		unique case (acfg_sel_t'(channel_input_select))
			ACFG_SEL_EXTERNAL: route_d = 4'h1;
			ACFG_SEL_SHORTED:  route_d = 4'h2;
			ACFG_SEL_TEST_POS: route_d = 4'h4;
			ACFG_SEL_TEST_NEG: route_d = 4'h8;
		endcase
		hp_d = global_highpass_on & ~channel_highpass_off;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			route_q <= 4'h1;
			hp_q    <= 1'b0;
		end else begin
			route_q <= route_d;
			hp_q    <= hp_d;
		end
	end

	assign route_external  = route_q[0];
	assign route_shorted   = route_q[1];
	assign route_test_pos  = route_q[2];
	assign route_test_neg  = route_q[3];
	assign highpass_enable = hp_q;

	a_route_onehot: assert property (@(posedge clock) disable iff (sys_rst)
		$onehot(route_q))
		else $error("input route not one-hot");
	a_route_follow: assert property (@(posedge clock) disable iff (sys_rst)
		channel_input_select == 2'b01 |=> route_shorted)
		else $error("shorted select not routed");
	a_hp_bypass: assert property (@(posedge clock) disable iff (sys_rst)
		channel_highpass_off |=> !highpass_enable)
		else $error("filter not bypassed");
	a_hp_global: assert property (@(posedge clock) disable iff (sys_rst)
		!channel_highpass_off |=> highpass_enable == $past(global_highpass_on))
		else $error("filter not under global control");
endmodule : acfg_route

// *** acfg_top.sv ***
// channel 0 configuration register with axi4-lite slave
//
// Contract
// - Config word holds phase in 15:6, zero-reading reserved 5:3, filter-off at 2, select at 1:0, all reset to zero.
// - The phase field is a signed ten-bit count of modulator clocks of delay or advance.
// - Filter-off clear leaves the channel filter under global control; set bypasses it for this channel.
// - Select routes the input: 00 external pair, 01 shorted, 10 positive test, 11 negative test.
`timescale 1ns/10ps
module acfg_top
	import acfg_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic [3:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [3:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic signed [9:0]       channel_phase_offset,
	output logic                    channel_highpass_off,
	output logic [1:0]              channel_input_select,
	output logic [3:0]              global_highpass_corner,
	output logic                    route_external,
	output logic                    route_shorted,
	output logic                    route_test_pos,
	output logic                    route_test_neg,
	output logic                    highpass_enable
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0] cfg_q,    cfg_d;
	logic [3:0]  corner_q, corner_d;
	logic        aw_q,     aw_d;
	logic [3:0]  awa_q,    awa_d;
	logic        w_q,      w_d;
	logic [31:0] wd_q,     wd_d;
	logic [3:0]  ws_q,     ws_d;
	logic        bv_q,     bv_d;
	logic [1:0]  br_q,     br_d;
	logic        rv_q,     rv_d;
	logic [31:0] rd_q,     rd_d;
	logic [1:0]  rr_q,     rr_d;
	logic [15:0] wval;
	logic        do_write;

	assign s_axi_awready = !aw_q && !bv_q;
	assign s_axi_wready  = !w_q && !bv_q;
	assign s_axi_arready = !rv_q;

	// ------------------------------------------------------------
	// bus next state
	// ------------------------------------------------------------
	always_comb begin
		aw_d     = aw_q;
		awa_d    = awa_q;
		w_d      = w_q;
		wd_d     = wd_q;
		ws_d     = ws_q;
		bv_d     = bv_q;
		br_d     = br_q;
		rv_d     = rv_q;
		rd_d     = rd_q;
		rr_d     = rr_q;
		cfg_d    = cfg_q;
		corner_d = corner_q;
		wval     = 16'h0000;
		do_write = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d  = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d  = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		// commit once address and data are both held
		if (aw_q && w_q) begin
			do_write = 1'b1;
			aw_d     = 1'b0;
			w_d      = 1'b0;
			bv_d     = 1'b1;
			br_d     = ACFG_RESP_OKAY;
			// merge strobed lanes into the old word
			wval     = cfg_q;
			if (ws_q[0])
				wval[7:0] = wd_q[7:0];
			if (ws_q[1])
				wval[15:8] = wd_q[15:8];
			unique case (awa_q)
				ACFG_OFF_CONFIG: cfg_d = wval & ACFG_WMASK;
				ACFG_OFF_CORNER: begin
					if (ws_q[0])
						corner_d = wd_q[3:0];
				end
				ACFG_OFF_STATUS: ;
				default: br_d = ACFG_RESP_SLVERR;
			endcase
		end
		if (bv_q && s_axi_bready)
			bv_d = 1'b0;
		if (rv_q && s_axi_rready)
			rv_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rv_d = 1'b1;
			rr_d = ACFG_RESP_OKAY;
			rd_d = 32'h0000_0000;
			unique case (s_axi_araddr)
				ACFG_OFF_CONFIG: rd_d = {16'h0000, cfg_q};
				ACFG_OFF_CORNER: rd_d = {28'h0000000, corner_q};
				ACFG_OFF_STATUS: rd_d = {27'h0000000, route_test_neg,
					route_test_pos, route_shorted, route_external,
					highpass_enable};
				default: rr_d = ACFG_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_q    <= ACFG_CONFIG_RST;
			corner_q <= ACFG_CORNER_RST;
			aw_q     <= 1'b0;
			awa_q    <= 4'h0;
			w_q      <= 1'b0;
			wd_q     <= 32'h0000_0000;
			ws_q     <= 4'h0;
			bv_q     <= 1'b0;
			br_q     <= 2'b00;
			rv_q     <= 1'b0;
			rd_q     <= 32'h0000_0000;
			rr_q     <= 2'b00;
		end else begin
			cfg_q    <= cfg_d;
			corner_q <= corner_d;
			aw_q     <= aw_d;
			awa_q    <= awa_d;
			w_q      <= w_d;
			wd_q     <= wd_d;
			ws_q     <= ws_d;
			bv_q     <= bv_d;
			br_q     <= br_d;
			rv_q     <= rv_d;
			rd_q     <= rd_d;
			rr_q     <= rr_d;
		end
	end

	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp  = br_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rdata  = rd_q;
	assign s_axi_rresp  = rr_q;

	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	assign channel_phase_offset =
		signed'(cfg_q[ACFG_PHASE_MSB:ACFG_PHASE_LSB]);
	assign channel_highpass_off   = cfg_q[ACFG_HPOFF_BIT];
	assign channel_input_select   = cfg_q[ACFG_SEL_MSB:ACFG_SEL_LSB];
	assign global_highpass_corner = corner_q;

	acfg_route u_route (
		.clock                (clock),
		.sys_rst              (sys_rst),
		.channel_input_select (channel_input_select),
		.channel_highpass_off (channel_highpass_off),
		.global_highpass_on   (|corner_q),
		.route_external       (route_external),
		.route_shorted        (route_shorted),
		.route_test_pos       (route_test_pos),
		.route_test_neg       (route_test_neg),
		.highpass_enable      (highpass_enable)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_rsvd_zero: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_q[5:3] == 3'b000)
		else $error("reserved config bits not zero");
	a_cfg_write: assert property (@(posedge clock) disable iff (sys_rst)
		do_write && awa_q == ACFG_OFF_CONFIG && ws_q == 4'hf
		|=> cfg_q == ($past(wd_q[15:0]) & ACFG_WMASK))
		else $error("config write not stored");
	a_phase_map: assert property (@(posedge clock) disable iff (sys_rst)
		do_write && awa_q == ACFG_OFF_CONFIG && ws_q[1:0] == 2'b11
		|=> channel_phase_offset ==
			$signed($past(wd_q[ACFG_PHASE_MSB:ACFG_PHASE_LSB])))
		else $error("phase field misplaced");
	a_strobe_lane: assert property (@(posedge clock) disable iff (sys_rst)
		do_write && awa_q == ACFG_OFF_CONFIG && ws_q[1:0] == 2'b01
		|=> cfg_q[15:8] == $past(cfg_q[15:8]))
		else $error("unstrobed config byte changed");
	a_unmapped_err: assert property (@(posedge clock) disable iff (sys_rst)
		do_write && awa_q != ACFG_OFF_CONFIG && awa_q != ACFG_OFF_STATUS
		&& awa_q != ACFG_OFF_CORNER
		|=> s_axi_bresp == ACFG_RESP_SLVERR && $stable(cfg_q))
		else $error("unmapped write not refused");
	a_cfg_read: assert property (@(posedge clock) disable iff (sys_rst)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ACFG_OFF_CONFIG
		|=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(cfg_q)})
		else $error("config readback wrong");
	a_sel_route: assert property (@(posedge clock) disable iff (sys_rst)
		channel_input_select == 2'b11 && $stable(channel_input_select)
		|-> route_test_neg)
		else $error("negative test signal not routed");
	a_hp_path: assert property (@(posedge clock) disable iff (sys_rst)
		channel_highpass_off && $past(channel_highpass_off)
		|-> !highpass_enable)
		else $error("filter bypass not applied");
endmodule : acfg_top

// *** tb_adc_channel_config_reg.sv ***
// self-checking bench for the channel 0 configuration register
`timescale 1ns/10ps
module tb_adc_channel_config_reg import acfg_pkg::*; ;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic              clock;
	logic              sys_rst;
	logic [3:0]        awaddr;
	logic              awvalid;
	logic              awready;
	logic [31:0]       wdata;
	logic [3:0]        wstrb;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [3:0]        araddr;
	logic              arvalid;
	logic              arready;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	logic signed [9:0] phase;
	logic              hp_off;
	logic [1:0]        sel_q;
	logic [3:0]        corner;
	logic              r_ext;
	logic              r_sho;
	logic              r_pos;
	logic              r_neg;
	logic              hp_en;
	logic [15:0]       cfg;
	logic [1:0]        sel;
	logic [9:0]        ph_tab [4];
	int                n_errors;
	int                checks_done;
	int                cycles;

	acfg_top dut (
		.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .channel_phase_offset(phase),
		.channel_highpass_off(hp_off), .channel_input_select(sel_q),
		.global_highpass_corner(corner), .route_external(r_ext),
		.route_shorted(r_sho), .route_test_pos(r_pos),
		.route_test_neg(r_neg), .highpass_enable(hp_en)
	);

	// ------------------------------------------------------------
	// clock, timeout, tasks
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		@(posedge clock);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge clock);
			aw_t = awvalid & awready;
			w_t = wvalid & wready;
			b_t = bvalid === 1'b1;
			r = bresp;
			@(posedge clock);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) bready <= 1'b0;
		end
		check(r, er);
	endtask : axi_write

	task automatic axi_read(input logic [3:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ar_t, r_t;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge clock);
			ar_t = arvalid & arready;
			r_t = rvalid === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge clock);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) rready <= 1'b0;
		end
		check(d, ed);
		check(r, er);
	endtask : axi_read

	task final_report;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, n_errors, checks_done, cycles} = '0;
		ph_tab = '{10'h200, 10'h1ff, 10'h3ff, 10'h001};
		sys_rst = 1'b1;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		axi_read(ACFG_OFF_CONFIG, 32'h0, ACFG_RESP_OKAY);
		axi_read(ACFG_OFF_STATUS, 32'h2, ACFG_RESP_OKAY);
		axi_write(ACFG_OFF_CORNER, 32'h5, 4'hf, ACFG_RESP_OKAY);
		axi_read(ACFG_OFF_CORNER, 32'h5, ACFG_RESP_OKAY);
		check(corner, 32'h5);
		for (int i = 0; i < 4; i++) begin
			sel = i[1:0];
			cfg = {ph_tab[i], 3'b000, i[0], sel};
			axi_write(ACFG_OFF_CONFIG, {16'h0, cfg}, 4'hf, ACFG_RESP_OKAY);
			axi_read(ACFG_OFF_CONFIG, {16'h0, cfg & 16'hffc7}, ACFG_RESP_OKAY);
			@(negedge clock);
			check({22'h0, phase}, ph_tab[i]);
			check(phase < 10'sd0, ph_tab[i][9]);
			check({hp_off, sel_q}, cfg[2:0]);
			check({r_neg, r_pos, r_sho, r_ext}, 4'b1 << sel);
			check(hp_en, !cfg[2]);
			axi_read(ACFG_OFF_STATUS, {27'h0, 4'b1 << sel, !cfg[2]}, 2'b00);
		end
		axi_write(ACFG_OFF_CONFIG, 32'h0, 4'hf, ACFG_RESP_OKAY);
		@(negedge clock);
		check(hp_en, 1'b1);
		axi_read(ACFG_OFF_CONFIG, 32'h0, ACFG_RESP_OKAY);
		axi_write(ACFG_OFF_CORNER, 32'h0, 4'hf, ACFG_RESP_OKAY);
		@(negedge clock);
		check(hp_en, 1'b0);
		check(corner, 32'h0);
		axi_write(ACFG_OFF_STATUS, 32'h1f, 4'hf, ACFG_RESP_OKAY);
		axi_read(ACFG_OFF_STATUS, 32'h2, ACFG_RESP_OKAY);
		axi_write(ACFG_OFF_CONFIG, 32'hffc7, 4'h1, ACFG_RESP_OKAY);
		axi_read(ACFG_OFF_CONFIG, 32'h00c7, ACFG_RESP_OKAY);
		axi_write(ACFG_OFF_CONFIG, 32'hffc7, 4'h2, ACFG_RESP_OKAY);
		axi_read(ACFG_OFF_CONFIG, 32'hffc7, ACFG_RESP_OKAY);
		axi_write(4'hc, 32'h1, 4'hf, ACFG_RESP_SLVERR);
		axi_read(4'hc, 32'h0, ACFG_RESP_SLVERR);
		axi_read(ACFG_OFF_CONFIG, 32'hffc7, ACFG_RESP_OKAY);
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		axi_read(ACFG_OFF_CONFIG, 32'h0, ACFG_RESP_OKAY);
		axi_read(ACFG_OFF_STATUS, 32'h2, ACFG_RESP_OKAY);
		final_report();
	end
endmodule : tb_adc_channel_config_reg
